// file: logic/intr_pkg.sv
package intr_pkg;

  // Source indices; a lower index wins when several are pending.
  localparam int NSRC        = 7;
  localparam int SRC_CMP     = 0;
  localparam int SRC_BOUNCE  = 1;
  localparam int SRC_TB0     = 2;
  localparam int SRC_TMR_P   = 3;
  localparam int SRC_TMR_A   = 4;
  localparam int SRC_EEPROM  = 5;
  localparam int SRC_TB1     = 6;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFF_CTRL_ZERO = 8'h00;
  localparam logic [7:0] OFF_CTRL_ONE  = 8'h04;
  localparam logic [7:0] OFF_STATUS    = 8'h08;

  // Field positions of control zero.
  localparam int C0_GIE_BIT  = 0;
  localparam int C0_EN_LSB   = 1;
  localparam int C0_FLAG_LSB = 4;
  localparam int C0_FIELD_W  = 3;

  // Field positions of control one.
  localparam int C1_EN_LSB   = 0;
  localparam int C1_FLAG_LSB = 4;
  localparam int C1_FIELD_W  = 4;

  // Field positions of the status register.
  localparam int ST_REQ_BIT   = 0;
  localparam int ST_SEL_LSB   = 1;
  localparam int ST_SEL_W     = 3;
  localparam int ST_DEPTH_LSB = 4;
  localparam int DEPTH_W      = 4;

  // Reset values.
  localparam logic [7:0] CTRL_ZERO_RESET = 8'h00;
  localparam logic [7:0] CTRL_ONE_RESET  = 8'h00;

  // Vector addresses, one per source index.
  localparam logic [15:0] VEC_ADDR [NSRC] = '{16'h0004, 16'h0008, 16'h000C, 16'h0010,
                                              16'h0014, 16'h0018, 16'h001C};

endpackage

// file: logic/req_flag_if.sv
`timescale 1ns/10ps
interface req_flag_if #(
  parameter int N = 7
);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] wr_en;
  logic [N-1:0] wr_val;
  logic [N-1:0] flag;
  logic [N-1:0] rise;

  modport bank (input set, input clr, input wr_en, input wr_val, output flag, output rise);
  modport ctrl (output set, output clr, output wr_en, output wr_val, input flag, input rise);
endinterface

// file: logic/req_flag_bank.sv
`timescale 1ns/10ps
module req_flag_bank #(
  parameter int N = 7
) (
  // Clock and reset.
  input wire logic  clk,
  input wire logic  rst_b,
  // Flag controls and state.
  req_flag_if.bank  bus
);

  logic [N-1:0] flag_reg;
  logic [N-1:0] flag_next;

  // A hardware event beats both a service clear and a software write in the same cycle.
  always_comb begin
    flag_next = flag_reg;
    flag_next = (flag_next & ~bus.wr_en) | (bus.wr_val & bus.wr_en);
    flag_next = flag_next & ~bus.clr;
    flag_next = flag_next | bus.set;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign bus.flag = flag_reg;
  // Only a zero to one change counts, so a flag already set gives no wake-up.
  assign bus.rise = flag_next & ~flag_reg;

endmodule

// file: logic/intr_ctrl.sv
`timescale 1ns/10ps
module intr_ctrl #(
  parameter int ADDR_W = 8,
  parameter int PC_W   = 12
) (
  // Clock and reset.
  input  wire logic              CLOCK,
  input  wire logic              RST_B,
  // Register bus.
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Event sources.
  input  wire logic              CMP_OUT,
  input  wire logic              BOUNCE_OUT,
  input  wire logic              TB0_OVF,
  input  wire logic              TB1_OVF,
  input  wire logic              EEPROM_WR_DONE,
  input  wire logic              TMR_P_MATCH,
  input  wire logic              TMR_A_MATCH,
  // Core and stack.
  input  wire logic [PC_W-1:0]   NEXT_PC,
  input  wire logic              STACK_FULL,
  input  wire logic              IRQ_ACK,
  input  wire logic              RETURN_FROM_INTERRUPT_EXEC,
  input  wire logic              SLEEP_MODE,
  output logic                   IRQ_REQ,
  output logic      [PC_W-1:0]   IRQ_VECTOR,
  output logic                   STACK_PUSH,
  output logic      [PC_W-1:0]   STACK_PUSH_DATA,
  output logic                   PC_LOAD,
  output logic      [PC_W-1:0]   PC_LOAD_VALUE,
  output logic                   STACK_POP,
  output logic                   WAKE
);

  localparam int N = intr_pkg::NSRC;

  generate
    if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must lie between 4 and 32");
    end
    if (PC_W < 5 || PC_W > 16) begin : g_bad_pc
      $error("PC_W must lie between 5 and 16");
    end
    // The source map and the select field are laid out for seven sources; the depth field must fit the status byte.
    if (N != intr_pkg::C0_FIELD_W + intr_pkg::C1_FIELD_W) begin : g_bad_split
      $error("The sources must fill the flag fields of both control registers");
    end
    if (N > 8 || intr_pkg::ST_SEL_W != 3) begin : g_bad_sel
      $error("The offered source index must fit the three bit select field");
    end
    if (intr_pkg::ST_DEPTH_LSB + intr_pkg::DEPTH_W > 8) begin : g_bad_depth
      $error("The depth field must fit in the status byte");
    end
    if (intr_pkg::C0_FLAG_LSB + intr_pkg::C0_FIELD_W > 7) begin : g_bad_c0
      $error("Bit 7 of control zero must stay free");
    end
    // A vector too wide for the counter would otherwise be cut silently by the cast in vec_of.
    for (genvar g = 0; g < N; g++) begin : g_vec_fit
      if ((int'(intr_pkg::VEC_ADDR[g]) >> PC_W) != 0) begin : g_bad_vec
        $error("A vector address does not fit in PC_W bits");
      end
    end
  endgenerate

  req_flag_if #(.N(N)) flags_if ();

  req_flag_bank #(.N(N)) u_flags (
    .clk   (CLOCK),
    .rst_b (RST_B),
    .bus   (flags_if.bank)
  );

  // Control state.
  logic                        global_en_reg;
  logic [N-1:0]                en_reg;
  logic                        irq_req_reg;
  logic [2:0]                  sel_reg;
  logic [PC_W-1:0]             vector_reg;
  logic                        push_reg;
  logic [PC_W-1:0]             push_data_reg;
  logic                        pc_load_reg;
  logic [PC_W-1:0]             pc_load_value_reg;
  logic                        pop_reg;
  logic                        wake_reg;
  logic [intr_pkg::DEPTH_W-1:0] depth_reg;

  // Event detection state.
  logic                        cmp_prev_reg;
  logic                        bounce_prev_reg;
  logic                        primed_reg;

  // Bus state.
  logic                        pready_reg;
  logic [31:0]                 prdata_reg;
  logic                        pslverr_reg;

  // Combinational terms.
  logic [N-1:0]                events;
  logic [N-1:0]                active;
  logic [2:0]                  sel;
  logic                        any_active;
  logic                        can_req;
  logic                        take;
  logic                        setup_phase;
  logic                        access_done;
  logic                        hit_zero;
  logic                        hit_one;
  logic                        hit_status;
  logic                        wr_zero;
  logic                        wr_one;
  logic [7:0]                  ctrl_zero_val;
  logic [7:0]                  ctrl_one_val;
  logic [7:0]                  status_val;

  function automatic logic [PC_W-1:0] vec_of(input logic [2:0] s);
    logic [PC_W-1:0] v;
    v = '0;
    for (int i = 0; i < N; i++) begin
      if (s == 3'(i)) begin
        v = PC_W'(intr_pkg::VEC_ADDR[i]);
      end
    end
    return v;
  endfunction

  // The level sources are compared against their last sample; the first sample after
  // reset only primes the history so that reset itself never looks like a transition.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      cmp_prev_reg    <= 1'b0;
      bounce_prev_reg <= 1'b0;
      primed_reg      <= 1'b0;
    end else begin
      cmp_prev_reg    <= CMP_OUT;
      bounce_prev_reg <= BOUNCE_OUT;
      primed_reg      <= 1'b1;
    end
  end

  // The pulse sources are one clock wide, so every high cycle counts as one event.
  always_comb begin
    events                       = '0;
    events[intr_pkg::SRC_CMP]    = primed_reg & (CMP_OUT ^ cmp_prev_reg);
    events[intr_pkg::SRC_BOUNCE] = primed_reg & (BOUNCE_OUT ^ bounce_prev_reg);
    events[intr_pkg::SRC_TB0]    = TB0_OVF;
    events[intr_pkg::SRC_TB1]    = TB1_OVF;
    events[intr_pkg::SRC_EEPROM] = EEPROM_WR_DONE;
    events[intr_pkg::SRC_TMR_P]  = TMR_P_MATCH;
    events[intr_pkg::SRC_TMR_A]  = TMR_A_MATCH;
  end

  // Events reach the bank whatever the enables hold; gating happens only towards the core.
  assign flags_if.set = events;

  // Bus decode.
  assign setup_phase = PSEL & ~PENABLE;
  assign access_done = PSEL & PENABLE & pready_reg;
  assign hit_zero    = PADDR == ADDR_W'(intr_pkg::OFF_CTRL_ZERO);
  assign hit_one     = PADDR == ADDR_W'(intr_pkg::OFF_CTRL_ONE);
  assign hit_status  = PADDR == ADDR_W'(intr_pkg::OFF_STATUS);
  // Only byte lane zero carries register bits, so a write without it changes nothing.
  assign wr_zero     = access_done & PWRITE & hit_zero & PSTRB[0];
  assign wr_one      = access_done & PWRITE & hit_one & PSTRB[0];

  // Software writes to the flag fields.
  always_comb begin
    flags_if.wr_en  = '0;
    flags_if.wr_val = '0;
    if (wr_zero) begin
      flags_if.wr_en[2:0]  = '1;
      flags_if.wr_val[2:0] = PWDATA[intr_pkg::C0_FLAG_LSB +: intr_pkg::C0_FIELD_W];
    end
    if (wr_one) begin
      flags_if.wr_en[6:3]  = '1;
      flags_if.wr_val[6:3] = PWDATA[intr_pkg::C1_FLAG_LSB +: intr_pkg::C1_FIELD_W];
    end
  end

  // Read values.
  always_comb begin
    ctrl_zero_val = '0;
    ctrl_zero_val[intr_pkg::C0_GIE_BIT] = global_en_reg;
    ctrl_zero_val[intr_pkg::C0_EN_LSB +: intr_pkg::C0_FIELD_W]   = en_reg[2:0];
    ctrl_zero_val[intr_pkg::C0_FLAG_LSB +: intr_pkg::C0_FIELD_W] = flags_if.flag[2:0];
    ctrl_one_val = '0;
    ctrl_one_val[intr_pkg::C1_EN_LSB +: intr_pkg::C1_FIELD_W]    = en_reg[6:3];
    ctrl_one_val[intr_pkg::C1_FLAG_LSB +: intr_pkg::C1_FIELD_W]  = flags_if.flag[6:3];
    status_val = '0;
    status_val[intr_pkg::ST_REQ_BIT] = irq_req_reg;
    status_val[intr_pkg::ST_SEL_LSB +: intr_pkg::ST_SEL_W]       = sel_reg;
    status_val[intr_pkg::ST_DEPTH_LSB +: intr_pkg::DEPTH_W]      = depth_reg;
  end

  // The slave answers in the first access cycle, so every transfer is two cycles long.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= ~(hit_zero | hit_one | hit_status);
      if (PWRITE) begin
        prdata_reg <= '0;
      end else if (hit_zero) begin
        prdata_reg <= {24'h000000, ctrl_zero_val};
      end else if (hit_one) begin
        prdata_reg <= {24'h000000, ctrl_one_val};
      end else if (hit_status) begin
        prdata_reg <= {24'h000000, status_val};
      end else begin
        prdata_reg <= '0;
      end
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // Fixed priority: the lowest pending enabled index wins.
  assign active     = flags_if.flag & en_reg;
  assign any_active = |active;

  always_comb begin
    sel = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (active[i]) begin
        sel = 3'(i);
      end
    end
  end

  assign can_req = global_en_reg & any_active & ~STACK_FULL;
  // The core's acknowledge is honoured only if the offered source is still valid now.
  assign take    = IRQ_ACK & irq_req_reg & global_en_reg & ~STACK_FULL & active[sel_reg];
  assign flags_if.clr = take ? (N'(1) << sel_reg) : '0;

  // Source enables.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      en_reg <= {intr_pkg::CTRL_ONE_RESET[intr_pkg::C1_EN_LSB +: intr_pkg::C1_FIELD_W],
                 intr_pkg::CTRL_ZERO_RESET[intr_pkg::C0_EN_LSB +: intr_pkg::C0_FIELD_W]};
    end else begin
      if (wr_zero) begin
        en_reg[2:0] <= PWDATA[intr_pkg::C0_EN_LSB +: intr_pkg::C0_FIELD_W];
      end
      if (wr_one) begin
        en_reg[6:3] <= PWDATA[intr_pkg::C1_EN_LSB +: intr_pkg::C1_FIELD_W];
      end
    end
  end

  // Service entry beats every other update so that the taken routine always starts blocked.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      global_en_reg <= intr_pkg::CTRL_ZERO_RESET[intr_pkg::C0_GIE_BIT];
    end else if (take) begin
      global_en_reg <= 1'b0;
    end else if (RETURN_FROM_INTERRUPT_EXEC) begin
      global_en_reg <= 1'b1;
    end else if (wr_zero) begin
      global_en_reg <= PWDATA[intr_pkg::C0_GIE_BIT];
    end
  end

  // Request offered to the core.
  // The vector follows the current winner every cycle, so it names the source that an ack would serve.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      irq_req_reg <= 1'b0;
      sel_reg     <= 3'h0;
      vector_reg  <= '0;
    end else begin
      irq_req_reg <= can_req & ~take;
      sel_reg     <= sel;
      vector_reg  <= vec_of(sel);
    end
  end

  // Entry and return actions towards the core and stack.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      push_reg          <= 1'b0;
      push_data_reg     <= '0;
      pc_load_reg       <= 1'b0;
      pc_load_value_reg <= '0;
      pop_reg           <= 1'b0;
    end else begin
      push_reg    <= take;
      pc_load_reg <= take;
      pop_reg     <= RETURN_FROM_INTERRUPT_EXEC;
      if (take) begin
        push_data_reg     <= NEXT_PC;
        pc_load_value_reg <= vec_of(sel_reg);
      end
    end
  end

  // Service depth, visible to software; saturates rather than wrapping.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      depth_reg <= '0;
    end else if (take && !RETURN_FROM_INTERRUPT_EXEC) begin
      if (depth_reg != '1) begin
        depth_reg <= depth_reg + 1'b1;
      end
    end else if (RETURN_FROM_INTERRUPT_EXEC && !take) begin
      if (depth_reg != '0) begin
        depth_reg <= depth_reg - 1'b1;
      end
    end
  end

  // Wake-up ignores every enable bit.
  // A flag written to one by software during sleep wakes as well, since that is a rise of the flag.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= SLEEP_MODE & (|flags_if.rise);
    end
  end

  assign PRDATA          = prdata_reg;
  assign PREADY          = pready_reg;
  assign PSLVERR         = pslverr_reg;
  assign IRQ_REQ         = irq_req_reg;
  assign IRQ_VECTOR      = vector_reg;
  assign STACK_PUSH      = push_reg;
  assign STACK_PUSH_DATA = push_data_reg;
  assign PC_LOAD         = pc_load_reg;
  assign PC_LOAD_VALUE   = pc_load_value_reg;
  assign STACK_POP       = pop_reg;
  assign WAKE            = wake_reg;

endmodule

// file: test/core_stack_model.sv
`timescale 1ns/10ps
module core_stack_model #(
  parameter int PC_W  = 12,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input  wire logic            clk,
  input  wire logic            rst_b,
  // Controller side.
  input  wire logic            irq_req,
  input  wire logic            push,
  input  wire logic            pop,
  // Bench control.
  input  wire logic            ack_en,
  // Core answers.
  output logic                 irq_ack,
  output logic      [PC_W-1:0] next_pc,
  output logic                 stack_full
);
  logic [3:0] depth_reg;

  // The ack lags the request by a cycle, like a core finishing its current instruction.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ack   <= 1'b0;
      next_pc   <= '0;
      depth_reg <= '0;
    end else begin
      irq_ack   <= irq_req && ack_en && !irq_ack;
      next_pc   <= next_pc + 1'b1;
      depth_reg <= depth_reg + 4'(push) - 4'(pop);
    end
  end

  assign stack_full = (depth_reg == 4'(DEPTH));
endmodule

// file: test/intr_ctrl_asserts.sv
`timescale 1ns/10ps
module intr_ctrl_asserts #(
  parameter int PC_W = 12
) (
  // Clock, reset and bus.
  input wire logic            CLOCK,
  input wire logic            RST_B,
  input wire logic            PSEL,
  input wire logic            PENABLE,
  input wire logic            PREADY,
  // Core and stack.
  input wire logic [PC_W-1:0] NEXT_PC,
  input wire logic            STACK_FULL,
  input wire logic            IRQ_ACK,
  input wire logic            RETURN_FROM_INTERRUPT_EXEC,
  input wire logic            SLEEP_MODE,
  input wire logic            IRQ_REQ,
  input wire logic [PC_W-1:0] IRQ_VECTOR,
  input wire logic            STACK_PUSH,
  input wire logic [PC_W-1:0] STACK_PUSH_DATA,
  input wire logic            PC_LOAD,
  input wire logic [PC_W-1:0] PC_LOAD_VALUE,
  input wire logic            STACK_POP,
  input wire logic            WAKE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  property p_take; IRQ_REQ && IRQ_ACK && !STACK_FULL |=> STACK_PUSH && PC_LOAD; endproperty
  a_take: assert property (p_take) else $error("ack did not enter service");
  property p_data; STACK_PUSH |-> STACK_PUSH_DATA == $past(NEXT_PC); endproperty
  a_data: assert property (p_data) else $error("wrong pushed address");
  property p_vec; PC_LOAD |-> PC_LOAD_VALUE == $past(IRQ_VECTOR); endproperty
  a_vec: assert property (p_vec) else $error("wrong vector loaded");
  property p_nonest; STACK_PUSH |-> !IRQ_REQ ##1 !STACK_PUSH; endproperty
  a_nonest: assert property (p_nonest) else $error("request kept after entry");
  property p_noreq; !(IRQ_REQ && IRQ_ACK) |=> !STACK_PUSH; endproperty
  a_noreq: assert property (p_noreq) else $error("entry without request");
  property p_full; STACK_FULL [*2] |-> !IRQ_REQ; endproperty
  a_full: assert property (p_full) else $error("request with full stack");
  property p_pop; STACK_POP == $past(RETURN_FROM_INTERRUPT_EXEC); endproperty
  a_pop: assert property (p_pop) else $error("pop not tied to return");
  property p_wake; WAKE |-> $past(SLEEP_MODE); endproperty
  a_wake: assert property (p_wake) else $error("wake outside sleep");
  property p_ready; PREADY |-> $past(PSEL && !PENABLE) && PSEL && PENABLE; endproperty
  a_ready: assert property (p_ready) else $error("ready outside access");

  c_take: cover property (STACK_PUSH);
  c_full: cover property (STACK_FULL && IRQ_ACK == 1'b0);
  c_wake: cover property (WAKE);
endmodule

bind intr_ctrl intr_ctrl_asserts #(.PC_W(PC_W)) i_chk (
  .CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .NEXT_PC(NEXT_PC), .STACK_FULL(STACK_FULL), .IRQ_ACK(IRQ_ACK), .RETURN_FROM_INTERRUPT_EXEC(RETURN_FROM_INTERRUPT_EXEC),
  .SLEEP_MODE(SLEEP_MODE), .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR), .STACK_PUSH(STACK_PUSH),
  .STACK_PUSH_DATA(STACK_PUSH_DATA), .PC_LOAD(PC_LOAD), .PC_LOAD_VALUE(PC_LOAD_VALUE),
  .STACK_POP(STACK_POP), .WAKE(WAKE)
);

// file: test/test_mcu_interrupt_controller.sv
`timescale 1ns/10ps
module test_mcu_interrupt_controller;
  logic        clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, irq_req, irq_ack, full, push, load, pop, wake;
  logic        cmp = 0, bnc = 0, return_from_interrupt = 0, sleep = 0, ack_en = 0;
  logic [6:2]  ev = '0;
  logic [11:0] next_pc, push_data, vec, load_val;
  int          fail_count = 0, n_checks = 0, cyc = 0, wakes = 0;

  always #10 clk = ~clk;

  intr_ctrl i_dut (
    .CLOCK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CMP_OUT(cmp), .BOUNCE_OUT(bnc), .TB0_OVF(ev[2]), .TB1_OVF(ev[6]), .EEPROM_WR_DONE(ev[5]),
    .TMR_P_MATCH(ev[3]), .TMR_A_MATCH(ev[4]), .NEXT_PC(next_pc), .STACK_FULL(full),
    .IRQ_ACK(irq_ack), .RETURN_FROM_INTERRUPT_EXEC(return_from_interrupt), .SLEEP_MODE(sleep), .IRQ_REQ(irq_req),
    .IRQ_VECTOR(vec), .STACK_PUSH(push), .STACK_PUSH_DATA(push_data), .PC_LOAD(load),
    .PC_LOAD_VALUE(load_val), .STACK_POP(pop), .WAKE(wake)
  );

  core_stack_model i_core (
    .clk(clk), .rst_b(rst_b), .irq_req(irq_req), .push(push), .pop(pop), .ack_en(ack_en),
    .irq_ack(irq_ack), .next_pc(next_pc), .stack_full(full)
  );

  always @(posedge clk) if (wake === 1'b1) wakes <= wakes + 1;

  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      end_sim;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Each transfer starts on a fresh edge so a release and the next setup never collide.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask

  task automatic fire(input int i);
    @(posedge clk);
    if (i == 0) cmp <= ~cmp;
    else if (i == 1) bnc <= ~bnc;
    else ev[i] <= 1'b1;
    @(posedge clk);
    ev <= '0;
    repeat (3) @(posedge clk);
  endtask

  task automatic ret;
    @(posedge clk);
    return_from_interrupt <= 1'b1;
    @(posedge clk);
    return_from_interrupt <= 1'b0;
  endtask

  task automatic wait_push(input logic [11:0] v);
    int n = 0;
    do @(posedge clk); while (push !== 1'b1 && n++ < 40);
    chk(32'({push, load_val}), 32'({1'b1, v}));
  endtask

  task automatic t_reset;
    logic [31:0] r;
    logic e;
    rd(intr_pkg::OFF_CTRL_ZERO, 32'(intr_pkg::CTRL_ZERO_RESET));
    rd(intr_pkg::OFF_CTRL_ONE, 32'(intr_pkg::CTRL_ONE_RESET));
    apb(1'b0, 8'h3C, 32'h0, r, e);
    chk(32'(e), 32'h1);
    wr(intr_pkg::OFF_CTRL_ZERO, 32'hFF);
    rd(intr_pkg::OFF_CTRL_ZERO, 32'h7F);
    wr(intr_pkg::OFF_CTRL_ONE, 32'hA5);
    rd(intr_pkg::OFF_CTRL_ONE, 32'hA5);
    wr(intr_pkg::OFF_CTRL_ZERO, 32'h00);
    wr(intr_pkg::OFF_CTRL_ONE, 32'h00);
  endtask

  task automatic t_pend;
    for (int i = 0; i < 7; i++) fire(i);
    rd(intr_pkg::OFF_CTRL_ZERO, 32'h70);
    rd(intr_pkg::OFF_CTRL_ONE, 32'hF0);
    wr(intr_pkg::OFF_CTRL_ZERO, 32'h71);
    repeat (2) @(posedge clk);
    chk(32'(irq_req), 32'h0);
    wr(intr_pkg::OFF_CTRL_ZERO, 32'h7E);
    wr(intr_pkg::OFF_CTRL_ONE, 32'hFF);
    repeat (2) @(posedge clk);
    chk(32'(irq_req), 32'h0);
  endtask

  task automatic t_prio;
    logic [6:0] pend = 7'h7F;
    ack_en <= 1'b1;
    wr(intr_pkg::OFF_CTRL_ZERO, 32'h7F);
    for (int i = 0; i < 7; i++) begin
      wait_push(intr_pkg::VEC_ADDR[i][11:0]);
      pend[i] = 1'b0;
      rd(intr_pkg::OFF_CTRL_ZERO, {25'h0, pend[2:0], 4'hE});
      rd(intr_pkg::OFF_CTRL_ONE, {24'h0, pend[6:3], 4'hF});
      ret;
    end
    rd(intr_pkg::OFF_CTRL_ZERO, 32'h0F);
  endtask

  task automatic t_nest;
    fire(0);
    wait_push(intr_pkg::VEC_ADDR[0][11:0]);
    fire(2);
    chk(32'(irq_req), 32'h0);
    rd(intr_pkg::OFF_CTRL_ZERO, 32'h4E);
    wr(intr_pkg::OFF_CTRL_ZERO, 32'h4F);
    wait_push(intr_pkg::VEC_ADDR[2][11:0]);
    fire(6);
    wr(intr_pkg::OFF_CTRL_ZERO, 32'h0F);
    repeat (3) @(posedge clk);
    chk(32'(irq_req), 32'h0);
    rd(intr_pkg::OFF_STATUS, 32'h2C);
    ret;
    wait_push(intr_pkg::VEC_ADDR[6][11:0]);
    ret;
    ret;
  endtask

  task automatic t_wake;
    int w;
    ack_en <= 1'b0;
    wr(intr_pkg::OFF_CTRL_ZERO, 32'h00);
    wr(intr_pkg::OFF_CTRL_ONE, 32'h00);
    sleep <= 1'b1;
    w = wakes;
    fire(5);
    chk(32'(wakes - w), 32'h1);
    fire(5);
    chk(32'(wakes - w), 32'h1);
    sleep <= 1'b0;
    wr(intr_pkg::OFF_CTRL_ONE, 32'h80);
    sleep <= 1'b1;
    fire(6);
    chk(32'(wakes - w), 32'h1);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_pend;
    t_prio;
    t_nest;
    t_wake;
    end_sim;
  end
endmodule
